// ==== rtl/scdr_ramp.sv ====
module scdr_ramp #(
  parameter int unsigned SLOW_CYCLES = scdr_pkg::SCDR_RAMP_SLOW_CYCLES,
  parameter int unsigned FAST_CYCLES = scdr_pkg::SCDR_RAMP_FAST_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // New coarse target
  input wire logic load,
  input wire logic [7:0] load_val,
  // Ramp controls
  input wire logic ramp_en,
  input wire logic fast,
  // Applied coarse code
  output logic [7:0] applied,
  output logic busy
);
  import scdr_pkg::*;

  scdr_ramp_st_s q;
  scdr_ramp_st_s d;
  logic [8:0] period;
  logic [7:0] step;
  logic [7:0] diff;
  logic [7:0] amount;
  logic up;

  ////////////////////////////////////////////////////////////////////////////
  // Step arithmetic, clamped so the ramp never passes its target
  always_comb begin
    period = fast ? SCDR_CNT_W'(FAST_CYCLES - 1) : SCDR_CNT_W'(SLOW_CYCLES - 1);
    step = fast ? SCDR_RAMP_FAST_STEP : SCDR_RAMP_SLOW_STEP;
    up = q.target > q.applied;
    diff = up ? q.target - q.applied : q.applied - q.target;
    amount = (diff < step) ? diff : step; // RULE_20
  end

  // Ramp sequencing
  always_comb begin
    d = q;
    case (q.fsm)
      SCDR_R_IDLE: begin
        if (!ramp_en) begin
          d.applied = q.target;
        end
      end
      SCDR_R_WAIT: begin
        if (!ramp_en) begin
          d.applied = q.target; // RULE_20
          d.fsm = SCDR_R_IDLE;
        end else if (q.cnt == period) begin
          d.cnt = '0;
          d.applied = up ? q.applied + amount : q.applied - amount; // RULE_16 RULE_17
          if (amount == diff) begin
            d.fsm = SCDR_R_IDLE; // RULE_20
          end
        end else begin
          d.cnt = q.cnt + SCDR_CNT_W'(1);
        end
      end
      default: begin
        d.fsm = SCDR_R_IDLE;
      end
    endcase
    // A write always restarts the interval toward the new value
    if (load) begin
      d.target = load_val; // RULE_18
      d.cnt = '0;
      if (ramp_en && load_val != q.applied) begin
        d.fsm = SCDR_R_WAIT; // RULE_16
      end else begin
        d.applied = load_val; // RULE_20
        d.fsm = SCDR_R_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign applied = q.applied;
  assign busy = (q.fsm == SCDR_R_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ramp_direct: assert property (load && !ramp_en |=> applied == $past(load_val)) // RULE_20
    else $error("coarse write without ramp not applied directly");
  a_ramp_slow_step: assert property (busy && ramp_en && !fast && !load && q.cnt == period
      |=> ((applied > $past(applied)) ? applied - $past(applied)
           : $past(applied) - applied) == SCDR_RAMP_SLOW_STEP) // RULE_17
    else $error("slow ramp step is not one code");
  a_ramp_hold: assert property (busy && ramp_en && !load && q.cnt != period
      |=> $stable(applied)) // RULE_17
    else $error("applied coarse moved between ramp intervals");
  a_ramp_no_over: assert property (busy && ramp_en && !load
      |=> ($past(up) ? applied <= $past(q.target) : applied >= $past(q.target))) // RULE_20
    else $error("ramp overshot its target");

  c_ramp_done: cover property (busy && ramp_en ##1 !busy);
  c_ramp_fast: cover property (busy && fast && q.cnt == period);

endmodule : scdr_ramp

// ==== rtl/scdr_top.sv ====
// Operation
// RULE_01 - Software sets mark enable before trigger status is output; clear means inactive.
// RULE_02 - When marking, output sample LSB carries trigger status instead of data.
// RULE_03 - Asynchronous trigger is sampled in step with the matching converter sample.
// RULE_04 - The one device clock drives sampling, processing and serializer timing.
// RULE_05 - Dual-channel mode samples once per clock, rising edge only.
// RULE_06 - Single-channel mode samples on both edges, doubling the rate.
// RULE_07 - The reference source may send one SYSREF pulse or a periodic one.
// RULE_08 - Periodic SYSREF runs at multiframe or multiblock clock rate, or a division.
// RULE_09 - SYSREF frequency follows the link framing formulas with integer n.
// RULE_10 - SYSREF is captured on a deterministic device clock edge every power-on.
// RULE_11 - Half-period invert control inverts the clock, one setting, half period delay.
// RULE_12 - Coarse and fine aperture delays each offer 256 settings.
// RULE_13 - Invert, coarse and fine delays are independent and add together.
// RULE_14 - All internal clocks shift by the programmed delay, SYSREF capture included.
// RULE_15 - Delay changes are accepted during operation and may disturb the link.
// RULE_16 - With ramping on, applied coarse delay walks gradually toward the new target.
// RULE_17 - Slow ramp: one step per 256 cycles; fast ramp: four per 384.
// RULE_18 - With ramp enabled, every coarse write starts a fresh ramp.
// RULE_19 - SYSREF calibration moves the sampling instant through the delay, not SYSREF.
// RULE_20 - Without ramp a coarse write applies at once; ramps stop exactly at target.
//
// Implementation choices: the address map and the APB slave port.
module scdr_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register bus
  input wire scdr_pkg::scdr_apb_req_s APB_REQ,
  output scdr_pkg::scdr_apb_rsp_s APB_RSP,
  // Converter samples in and marked samples out
  input wire scdr_pkg::scdr_sample_s CONV_IN,
  output scdr_pkg::scdr_sample_s SAMPLE_OUT,
  // Trigger pins, differential
  input wire logic TRIGGER_IN_POS,
  input wire logic TRIGGER_IN_NEG,
  // Timing reference
  input wire logic SYSREF_IN,
  output logic SYSREF_CAPTURE,
  // Clock path control
  output scdr_pkg::scdr_delay_s DELAY_OUT,
  output scdr_pkg::scdr_edges_s SAMPLE_EDGES
);
  import scdr_pkg::*;

  scdr_top_st_s q;
  scdr_top_st_s d;
  logic wr_acc;
  logic rd_setup;
  logic acc;
  logic hit;
  logic coarse_load;
  logic [7:0] coarse_val;
  logic trig_status;
  logic sr_edge;
  logic [7:0] applied;
  logic busy;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; a write lands only in the access phase
  always_comb begin
    acc = APB_REQ.psel && APB_REQ.penable;
    wr_acc = acc && APB_REQ.pwrite;
    rd_setup = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
    hit = (APB_REQ.paddr == SCDR_OFF_CTRL) || (APB_REQ.paddr == SCDR_OFF_COARSE)
      || (APB_REQ.paddr == SCDR_OFF_FINE) || (APB_REQ.paddr == SCDR_OFF_STATUS);
  end

  // Synchronised pins; the trigger pair is read at its second flops, the SYSREF edge from its second and third flops
  always_comb begin
    trig_status = q.tp2 && !q.tn2; // RULE_03
    sr_edge = q.sr2 && !q.sr3; // RULE_10
  end

  // Coarse target source: software write wins over a calibration step
  always_comb begin
    coarse_load = 1'b0;
    coarse_val = q.coarse;
    if (wr_acc && APB_REQ.paddr == SCDR_OFF_COARSE) begin
      coarse_load = 1'b1; // RULE_15 RULE_18
      coarse_val = APB_REQ.pwdata[7:0]; // RULE_12
    end else if (q.cal_en && q.capture && q.coarse != SCDR_COARSE_MAX) begin
      // Calibration nudges the sampling instant rather than delaying SYSREF
      coarse_load = 1'b1; // RULE_19
      coarse_val = q.coarse + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // Control writes
    if (wr_acc) begin
      case (APB_REQ.paddr)
        SCDR_OFF_CTRL: begin
          d.inv = APB_REQ.pwdata[SCDR_CTRL_INV_BIT]; // RULE_11
          d.ramp_en = APB_REQ.pwdata[SCDR_CTRL_RAMP_EN_BIT];
          d.fast = APB_REQ.pwdata[SCDR_CTRL_FAST_BIT];
          d.mark_en = APB_REQ.pwdata[SCDR_CTRL_MARK_BIT]; // RULE_01
          d.single = APB_REQ.pwdata[SCDR_CTRL_SINGLE_BIT];
          d.cal_en = APB_REQ.pwdata[SCDR_CTRL_CAL_BIT];
        end
        SCDR_OFF_FINE: begin
          d.fine = APB_REQ.pwdata[7:0]; // RULE_12 RULE_15
        end
        default: begin
          d.fine = q.fine;
        end
      endcase
    end
    if (coarse_load) begin
      d.coarse = coarse_val;
    end

    // Two flop synchronisers for trigger pair and SYSREF
    d.tp1 = TRIGGER_IN_POS;
    d.tp2 = q.tp1;
    d.tn1 = TRIGGER_IN_NEG;
    d.tn2 = q.tn1;
    d.sr1 = SYSREF_IN;
    d.sr2 = q.sr1;
    d.sr3 = q.sr2;

    // Capture pulse works for a lone pulse as well as a periodic reference
    d.capture = sr_edge; // RULE_07 RULE_10
    if (sr_edge) begin
      d.seen = 1'b1;
      d.sr_count = q.sr_count + 8'h01;
    end

    // Sample pipeline matches the synchroniser depth so marks line up
    d.pipe1 = CONV_IN; // RULE_03
    d.pipe2 = q.pipe1;
    d.out = q.pipe2;
    // Dual mode has no falling edge sample
    if (!q.single) begin
      d.out.fall_vld = 1'b0; // RULE_05
      d.out.fall_data = '0;
    end
    if (q.mark_en) begin
      d.out.rise_data[0] = trig_status; // RULE_02
      d.out.fall_data[0] = q.single ? trig_status : 1'b0; // RULE_06
    end

    // Read data is built in the setup phase, held for the access phase
    if (rd_setup) begin
      d.prdata = SCDR_RDATA_ZERO;
      case (APB_REQ.paddr)
        SCDR_OFF_CTRL: begin
          d.prdata[SCDR_CTRL_INV_BIT] = q.inv;
          d.prdata[SCDR_CTRL_RAMP_EN_BIT] = q.ramp_en;
          d.prdata[SCDR_CTRL_FAST_BIT] = q.fast;
          d.prdata[SCDR_CTRL_MARK_BIT] = q.mark_en;
          d.prdata[SCDR_CTRL_SINGLE_BIT] = q.single;
          d.prdata[SCDR_CTRL_CAL_BIT] = q.cal_en;
        end
        SCDR_OFF_COARSE: begin
          d.prdata[7:0] = q.coarse;
        end
        SCDR_OFF_FINE: begin
          d.prdata[7:0] = q.fine;
        end
        SCDR_OFF_STATUS: begin
          d.prdata[SCDR_ST_APPLIED_LSB +: SCDR_DW] = applied;
          d.prdata[SCDR_ST_BUSY_BIT] = busy;
          d.prdata[SCDR_ST_SEEN_BIT] = q.seen;
          d.prdata[SCDR_ST_TRIG_BIT] = trig_status;
          d.prdata[SCDR_ST_COUNT_LSB +: SCDR_DW] = q.sr_count;
        end
        default: begin
          d.prdata = SCDR_RDATA_ZERO;
        end
      endcase
    end
  end

  // State register; every flop resets to zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coarse ramp engine
  scdr_ramp #(
    .SLOW_CYCLES(SCDR_RAMP_SLOW_CYCLES),
    .FAST_CYCLES(SCDR_RAMP_FAST_CYCLES)
  ) u_ramp (
    .clk(CLOCK),
    .rst_n(RST_N),
    .load(coarse_load),
    .load_val(coarse_val),
    .ramp_en(q.ramp_en),
    .fast(q.fast),
    .applied(applied),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Zero wait state slave: every access completes in its first access cycle
  assign APB_RSP.prdata = q.prdata;
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = acc && !hit;

  // The three delay stages leave as separate codes; the analog path sums them
  assign DELAY_OUT.invert = q.inv; // RULE_11 RULE_13
  assign DELAY_OUT.coarse = applied; // RULE_13 RULE_16
  assign DELAY_OUT.fine = q.fine; // RULE_13
  // Settling warns the link side while the clock phase still moves
  assign DELAY_OUT.settling = busy; // RULE_15

  // Edge enables for the sampler; the same delayed clock feeds every domain,
  // so SYSREF capture and serializer timing move with the delay
  assign SAMPLE_EDGES.rise_en = 1'b1; // RULE_04 RULE_05 RULE_14
  assign SAMPLE_EDGES.fall_en = q.single; // RULE_06

  assign SAMPLE_OUT = q.out;
  assign SYSREF_CAPTURE = q.capture;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_mark_lsb_rise: assert property ($past(q.mark_en) && SAMPLE_OUT.rise_vld
      |-> SAMPLE_OUT.rise_data[0] == $past(trig_status)) // RULE_02
    else $error("marked sample lsb differs from trigger status");
  a_mark_off_data: assert property (!q.mark_en && !wr_acc
      |=> SAMPLE_OUT.rise_data == $past(q.pipe2.rise_data)) // RULE_01
    else $error("sample data altered while marking disabled");
  a_trig_align: assert property (q.mark_en && !wr_acc && TRIGGER_IN_POS && !TRIGGER_IN_NEG
      ##1 (q.mark_en && $stable(TRIGGER_IN_POS) && $stable(TRIGGER_IN_NEG)) [*2]
      |=> SAMPLE_OUT.rise_data[0]) // RULE_03
    else $error("trigger not marked three cycles after its pins");
  a_dual_no_fall: assert property (!q.single && !wr_acc |=> !SAMPLE_OUT.fall_vld) // RULE_05
    else $error("falling edge sample shown in dual mode");
  a_single_edges: assert property (SAMPLE_EDGES.fall_en == q.single
      && SAMPLE_EDGES.rise_en) // RULE_06
    else $error("edge enables do not match channel mode");
  a_sysref_pulse: assert property ($rose(q.sr2) |=> SYSREF_CAPTURE ##1 !SYSREF_CAPTURE) // RULE_10
    else $error("sysref capture is not a single cycle pulse");
  a_fine_write: assert property (wr_acc && APB_REQ.paddr == SCDR_OFF_FINE
      |=> DELAY_OUT.fine == $past(APB_REQ.pwdata[7:0])) // RULE_12
    else $error("fine delay write not applied");
  a_cal_advance: assert property (q.cal_en && q.capture && !wr_acc
      && q.coarse != SCDR_COARSE_MAX |=> q.coarse == $past(q.coarse) + 8'h01) // RULE_19
    else $error("calibration did not advance coarse target");
  a_inv_write: assert property (wr_acc && APB_REQ.paddr == SCDR_OFF_CTRL
      |=> DELAY_OUT.invert == $past(APB_REQ.pwdata[SCDR_CTRL_INV_BIT])) // RULE_11
    else $error("invert control not applied");
  a_ramp_start: assert property (q.ramp_en && wr_acc && APB_REQ.paddr == SCDR_OFF_COARSE
      && APB_REQ.pwdata[7:0] != applied |=> DELAY_OUT.settling) // RULE_18
    else $error("coarse write under ramp did not start a ramp");
  a_apb_unmapped: assert property (acc && !hit |-> APB_RSP.pslverr && APB_RSP.pready)
    else $error("unmapped access not flagged");

  // The rise valid flag rides the three stage pipeline untouched; guarded so reset history is ignored
  a_rise_vld_pass: assert property ($past(RST_N, 3)
      |-> SAMPLE_OUT.rise_vld == $past(CONV_IN.rise_vld, 3)) // RULE_03
    else $error("rise valid flag lost in sample pipeline");
  // Single mode must keep the falling lane flag as it arrived
  a_single_fall: assert property (q.single
      |=> SAMPLE_OUT.fall_vld == $past(q.pipe2.fall_vld)) // RULE_06
    else $error("falling lane flag dropped in single mode");
  // Edge counter moves by one with each capture pulse
  a_sr_count: assert property (q.capture
      |-> q.sr_count == $past(q.sr_count) + 8'h01) // RULE_10
    else $error("sysref edge count did not advance");
  // A capture pulse never lasts two cycles
  a_cap_gap: assert property (SYSREF_CAPTURE |=> !SYSREF_CAPTURE) // RULE_10
    else $error("sysref capture held longer than one cycle");
  // With no ramp running, the applied code is the target
  a_idle_target: assert property (!busy |-> DELAY_OUT.coarse == q.coarse) // RULE_20
    else $error("idle applied coarse differs from target");
  // A coarse write with ramping off never leaves the engine busy
  a_ramp_nostart: assert property (!q.ramp_en && coarse_load
      |=> !DELAY_OUT.settling) // RULE_20
    else $error("ramp ran although it was disabled");
  // Fine code only moves on its own write
  a_fine_hold: assert property (!(wr_acc && APB_REQ.paddr == SCDR_OFF_FINE)
      |=> $stable(DELAY_OUT.fine)) // RULE_15
    else $error("fine delay moved without a write");
  // Inversion only moves on a control write
  a_inv_hold: assert property (!(wr_acc && APB_REQ.paddr == SCDR_OFF_CTRL)
      |=> $stable(DELAY_OUT.invert)) // RULE_11
    else $error("invert control moved without a write");

  c_marked_sample: cover property (q.mark_en && SAMPLE_OUT.rise_vld && SAMPLE_OUT.rise_data[0]);
  c_single_mode: cover property (q.single && SAMPLE_OUT.fall_vld);
  c_cal_step: cover property (q.cal_en && q.capture);
  c_ramp_run: cover property ($rose(DELAY_OUT.settling));

endmodule : scdr_top

// ==== shared/scdr_pkg.sv ====
package scdr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on APB
  localparam int unsigned SCDR_AW = 16;
  localparam logic [15:0] SCDR_OFF_CTRL = 16'h0000;
  localparam logic [15:0] SCDR_OFF_COARSE = 16'h0004;
  localparam logic [15:0] SCDR_OFF_FINE = 16'h0008;
  localparam logic [15:0] SCDR_OFF_STATUS = 16'h000C;

  // Control register field positions
  localparam int unsigned SCDR_CTRL_INV_BIT = 0;
  localparam int unsigned SCDR_CTRL_RAMP_EN_BIT = 1;
  localparam int unsigned SCDR_CTRL_FAST_BIT = 2;
  localparam int unsigned SCDR_CTRL_MARK_BIT = 3;
  localparam int unsigned SCDR_CTRL_SINGLE_BIT = 4;
  localparam int unsigned SCDR_CTRL_CAL_BIT = 5;

  // Status register field positions
  localparam int unsigned SCDR_ST_APPLIED_LSB = 0;
  localparam int unsigned SCDR_ST_BUSY_BIT = 8;
  localparam int unsigned SCDR_ST_SEEN_BIT = 9;
  localparam int unsigned SCDR_ST_TRIG_BIT = 10;
  localparam int unsigned SCDR_ST_COUNT_LSB = 16;

  // Delay code width: 256 settings each for coarse and fine
  localparam int unsigned SCDR_DW = 8;
  localparam logic [7:0] SCDR_COARSE_RST = 8'h00;
  localparam logic [7:0] SCDR_FINE_RST = 8'h00;
  localparam logic [7:0] SCDR_COARSE_MAX = 8'hFF;
  localparam logic [31:0] SCDR_RDATA_ZERO = 32'h0000_0000;

  // Ramp timing: slow 1 step per 256 cycles, fast 4 steps per 384 cycles
  localparam int unsigned SCDR_RAMP_SLOW_CYCLES = 256;
  localparam int unsigned SCDR_RAMP_FAST_CYCLES = 384;
  localparam logic [7:0] SCDR_RAMP_SLOW_STEP = 8'h01;
  localparam logic [7:0] SCDR_RAMP_FAST_STEP = 8'h04;
  localparam int unsigned SCDR_CNT_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [0:0] {
    SCDR_R_IDLE = 1'b0,
    SCDR_R_WAIT = 1'b1
  } scdr_ramp_e;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } scdr_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scdr_apb_rsp_s;

  typedef struct packed {
    logic rise_vld;
    logic [7:0] rise_data;
    logic fall_vld;
    logic [7:0] fall_data;
  } scdr_sample_s;

  typedef struct packed {
    logic invert;
    logic [7:0] coarse;
    logic [7:0] fine;
    logic settling;
  } scdr_delay_s;

  typedef struct packed {
    logic rise_en;
    logic fall_en;
  } scdr_edges_s;

  // Ramp engine state
  typedef struct packed {
    scdr_ramp_e fsm;
    logic [7:0] applied;
    logic [7:0] target;
    logic [8:0] cnt;
  } scdr_ramp_st_s;

  // Top level state
  typedef struct packed {
    logic inv;
    logic ramp_en;
    logic fast;
    logic mark_en;
    logic single;
    logic cal_en;
    logic [7:0] coarse;
    logic [7:0] fine;
    logic tp1;
    logic tp2;
    logic tn1;
    logic tn2;
    logic sr1;
    logic sr2;
    logic sr3;
    logic capture;
    logic seen;
    logic [7:0] sr_count;
    scdr_sample_s pipe1;
    scdr_sample_s pipe2;
    scdr_sample_s out;
    logic [31:0] prdata;
  } scdr_top_st_s;

endpackage : scdr_pkg

// ==== test/scdr_partner.sv ====
module scdr_partner #(
  // Link framing figures, plain defaults
  parameter int unsigned LINK_R = 1,
  parameter int unsigned LINK_F = 2,
  parameter int unsigned LINK_K = 4,
  parameter int unsigned LINK_N = 1
) (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic trig_lvl,
  input wire logic [3:0] pulses,
  input wire logic go,
  // Pins toward the device
  output logic trig_pos,
  output logic trig_neg,
  output logic sysref
);
  // Reference period in device clocks, 8b/10b framing
  localparam int unsigned PERIOD = 10 * LINK_F * LINK_K * LINK_N / LINK_R;

  int unsigned left;
  int unsigned ph;

  initial begin
    trig_pos = 1'b0;
    trig_neg = 1'b1;
    sysref = 1'b0;
    left = 0;
    ph = 0;
  end

  // Trigger moves between sampling edges, as a truly async source would
  always @(negedge clk) begin
    trig_pos <= trig_lvl;
    trig_neg <= ~trig_lvl;
  end

  // One pulse or a periodic run, by the count asked for
  always @(negedge clk) begin
    if (go) begin
      left <= pulses;
      ph <= 0;
    end else if (left != 0) begin
      sysref <= (ph < PERIOD / 2);
      if (ph == PERIOD - 1) begin
        ph <= 0;
        left <= left - 1;
      end else begin
        ph <= ph + 1;
      end
    end else begin
      sysref <= 1'b0;
    end
  end
endmodule : scdr_partner

// ==== test/scdr_top_bench.sv ====
module scdr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import scdr_pkg::*;

  logic clk;
  logic rst_n;
  scdr_apb_req_s req;
  scdr_apb_rsp_s rsp;
  scdr_sample_s cin;
  scdr_sample_s sout;
  scdr_delay_s dly;
  scdr_edges_s edg;
  logic tp;
  logic tn;
  logic sr;
  logic cap;
  logic trig_lvl;
  logic go;
  logic [3:0] pulses;
  logic [31:0] rd;
  logic err;
  int n;
  int n_errors = 0;
  int checks = 0;

  scdr_top dut (.CLOCK(clk), .RST_N(rst_n), .APB_REQ(req), .APB_RSP(rsp), .CONV_IN(cin),
    .SAMPLE_OUT(sout), .TRIGGER_IN_POS(tp), .TRIGGER_IN_NEG(tn), .SYSREF_IN(sr),
    .SYSREF_CAPTURE(cap), .DELAY_OUT(dly), .SAMPLE_EDGES(edg));
  scdr_partner far (.clk(clk), .trig_lvl(trig_lvl), .pulses(pulses), .go(go),
    .trig_pos(tp), .trig_neg(tn), .sysref(sr));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Cycles until the applied coarse code moves, seen mid-cycle
  task automatic wait_move(output int m);
    logic [7:0] old;
    old = dly.coarse;
    m = 0;
    do begin
      @(negedge clk);
      m++;
    end while (dly.coarse === old && m < 2000);
  endtask : wait_move

  task automatic fire(input logic [3:0] p);
    @(posedge clk);
    pulses <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    @(negedge clk);
    check("edges", edg, 2'b10);
    check("delay", dly, '0);
    apb(1'b0, SCDR_OFF_STATUS, '0);
    check("status", rd, 32'h0000_0000);
    apb(1'b1, 16'h0040, 32'hFFFF_FFFF);
    check("unmapped err", err, 1'b1);
  endtask : t_reset

  task automatic t_direct;
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_00FF);
    apb(1'b1, SCDR_OFF_FINE, 32'h0000_00AB);
    repeat (2) @(negedge clk);
    check("invert", dly.invert, 1'b1);
    check("coarse", dly.coarse, 8'hFF);
    check("fine", dly.fine, 8'hAB);
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check("invert off", dly.invert, 1'b0);
    check("coarse zero", dly.coarse, 8'h00);
    check("fine kept", dly.fine, 8'hAB);
  endtask : t_direct

  task automatic t_slow;
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0002);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_0003);
    wait_move(n);
    check("slow first", n inside {[256:258]}, 1'b1);
    check("slow step", dly.coarse, 8'h01);
    check("settling", dly.settling, 1'b1);
    wait_move(n);
    check("slow gap", n, 256);
    wait_move(n);
    check("slow end", dly.coarse, 8'h03);
    repeat (300) @(negedge clk);
    check("no overshoot", dly.coarse, 8'h03);
    check("settled", dly.settling, 1'b0);
  endtask : t_slow

  task automatic t_restart;
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_0001);
    repeat (100) @(negedge clk);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_0005);
    wait_move(n);
    check("restart gap", n inside {[256:258]}, 1'b1);
    check("restart dir", dly.coarse, 8'h04);
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check("ramp off jump", dly.coarse, 8'h05);
  endtask : t_restart

  task automatic t_fast;
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0006);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_000B);
    wait_move(n);
    check("fast first", n inside {[384:386]}, 1'b1);
    check("fast step", dly.coarse, 8'h09);
    wait_move(n);
    check("fast gap", n, 384);
    check("fast end", dly.coarse, 8'h0B);
    apb(1'b0, SCDR_OFF_STATUS, '0);
    check("status applied", rd[7:0], 8'h0B);
  endtask : t_fast

  // Every mix of marking, trigger level and channel mode
  task automatic t_mark;
    logic m;
    logic t;
    logic s;
    logic [7:0] a;
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      {s, t, m} = 3'(i);
      a = 8'hA4 ^ 8'(i);
      b = 8'h5A ^ 8'(i);
      trig_lvl <= t;
      apb(1'b1, SCDR_OFF_CTRL, {26'd0, 1'b0, s, m, 3'b000});
      cin <= '{rise_vld: 1'b1, rise_data: a, fall_vld: 1'b1, fall_data: b};
      repeat (6) @(negedge clk);
      check("rise lane", sout.rise_data, m ? {a[7:1], t} : a);
      check("rise vld", sout.rise_vld, 1'b1);
      check("fall vld", sout.fall_vld, s);
      check("fall lane", sout.fall_data, !s ? 8'h00 : m ? {b[7:1], t} : b);
      check("fall edge", edg.fall_en, s);
      apb(1'b0, SCDR_OFF_STATUS, '0);
      check("trig status", rd[SCDR_ST_TRIG_BIT], t);
    end
  endtask : t_mark

  task automatic t_sysref;
    fire(4'd1);
    @(posedge sr);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cap !== 1'b1 && n < 20);
    check("capture delay", n inside {[3:4]}, 1'b1);
    @(negedge clk);
    check("capture width", cap, 1'b0);
    repeat (100) @(negedge clk);
    fire(4'd3);
    repeat (260) @(negedge clk);
    apb(1'b0, SCDR_OFF_STATUS, '0);
    check("seen", rd[SCDR_ST_SEEN_BIT], 1'b1);
    check("edge count", rd[23:16], 8'h04);
    apb(1'b1, SCDR_OFF_CTRL, 32'h0000_0020);
    apb(1'b1, SCDR_OFF_COARSE, 32'h0000_0010);
    fire(4'd2);
    repeat (200) @(negedge clk);
    check("cal walk", dly.coarse, 8'h12);
  endtask : t_sysref

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    cin = '0;
    trig_lvl = 1'b0;
    go = 1'b0;
    pulses = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_direct();
    t_slow();
    t_restart();
    t_fast();
    t_mark();
    t_sysref();
    give_verdict();
  end

  // Watchdog, well past the few thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD watchdog expired");
    give_verdict();
  end
endmodule : scdr_top_bench
